// ===== common/pport_pkg.sv
// Shared constants and types of the parallel port configuration block.
package pport_pkg;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int BYTE_W = 8;
   localparam int NBYTES = 4;
   localparam int PIN_W = 11;
   // ***************************************************
   // Register offsets (word index on the register port)
   // ***************************************************
   localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_MODE = 4'h1;
   localparam logic [ADDR_W-1:0] OFS_ADDR = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_PIN_EN = 4'h3;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PAD = 4'h5;
   localparam logic [ADDR_W-1:0] OFS_OUT1 = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_OUT2 = 4'h7;
   localparam logic [ADDR_W-1:0] OFS_IN1 = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_IN2 = 4'h9;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'hA;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'hB;
   // ***************************************************
   // Field positions and implemented-bit masks
   // ***************************************************
   localparam int CTL_PORT_EN = 15;
   localparam int CTL_CAL_OE = 10;
   localparam int MODE_BUSY = 15;
   localparam int MODE_SEL_LO = 8;
   localparam int SETUP_LO = 6;
   localparam int MIDDLE_LO = 2;
   localparam int HOLD_LO = 0;
   localparam int ADDR_CS = 14;
   localparam int PIN_CS = 14;
   localparam int PAD_TTL = 0;
   localparam int PAD_SEC = 1;
   localparam int ST_IBF = 15;
   localparam int ST_INPUT_OVERFLOW_FLAG = 14;
   localparam int ST_IBX = 8;
   localparam int ST_OBE = 7;
   localparam int ST_OUTPUT_UNDERFLOW_FLAG = 6;
   localparam int ST_OBX = 0;
   localparam logic [DATA_W-1:0] CTL_MASK = 16'h8400;
   localparam logic [DATA_W-1:0] MODE_MASK = 16'h7FFF;
   localparam logic [DATA_W-1:0] ADDR_MASK = 16'h47FF;
   localparam logic [DATA_W-1:0] PIN_EN_MASK = 16'h47FF;
   localparam logic [DATA_W-1:0] PAD_MASK = 16'h0003;
   // ***************************************************
   // Interrupt events and timing
   // ***************************************************
   localparam int IRQ_W = 4;
   localparam int IRQ_OVF = 0;
   localparam int IRQ_UNF = 1;
   localparam int IRQ_HOST_WR = 2;
   localparam int IRQ_DONE = 3;
   localparam int CNT_W = 6;
   localparam logic [CNT_W-1:0] STROBE_CYCLES = 6'h01;
   localparam logic [CNT_W-1:0] PHASE_BASE = 6'h01;
   typedef enum logic [1:0] {
      MODE_LEGACY_SLAVE = 2'b00,
      MODE_ADDR_SLAVE = 2'b01,
      MODE_MASTER2 = 2'b10,
      MODE_MASTER1 = 2'b11
   } port_mode_type;
   typedef enum logic {
      XFER_IDLE = 1'b0,
      XFER_ACTIVE = 1'b1
   } xfer_state_type;
endpackage

// ===== src/parallel_port_config_status.sv
// Parallel port configuration, pin ownership, slave buffers and status.
//
// Function
// - Middle wait zero ignores setup and hold
// - Chip-select pin owned when its enable set
// - Upper address pin enables give pins away
// - Low two pin enables give address pins in master modes
// - Address register drives address lines
// - Pad bit selects TTL or Schmitt inputs
// - Pad bit picks seconds clock or alarm
// - Calendar pin driven only when enabled
// - Unimplemented register bits read zero
// - Host address low bits pick buffer byte in addressable slave mode
// - Host read of empty byte flags underflow
// - Input full flags clear on software read
// - Mode 11 uses read/write plus enable
// - Port disabled performs no off-chip access
module parallel_port_config_status (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [pport_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [pport_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [pport_pkg::DATA_W-1:0] reg_rdata,
   input wire logic host_cs_in,
   input wire logic host_rd_in,
   input wire logic host_wr_in,
   input wire logic [1:0] host_addr_in,
   input wire logic [pport_pkg::BYTE_W-1:0] pdata_in,
   output logic [pport_pkg::BYTE_W-1:0] pdata_out,
   output logic pdata_oe_n,
   output logic [pport_pkg::PIN_W-1:0] addr_out,
   output logic [pport_pkg::PIN_W-1:0] addr_oe_n,
   output logic cs_out,
   output logic cs_oe_n,
   output logic strobe_rd_out,
   output logic strobe_wr_out,
   output logic strobe_oe_n,
   input wire logic cal_seconds_clk,
   input wire logic cal_alarm_pulse,
   output logic cal_pin_out,
   output logic ttl_select,
   output logic irq
);
   localparam int SYNC_W = 3 + 2 + pport_pkg::BYTE_W;

   typedef struct packed {
      logic [15:0] control;
      logic [15:0] mode;
      logic [15:0] taddr;
      logic [15:0] pin_en;
      logic [15:0] pad;
      logic [3:0][7:0] in_bytes;
      logic [3:0][7:0] out_bytes;
      logic [3:0] in_full;
      logic [3:0] out_empty;
      logic input_overflow_flag;
      logic output_underflow_flag;
      logic [pport_pkg::IRQ_W-1:0] irq_stat;
      logic [pport_pkg::IRQ_W-1:0] irq_mask;
      logic [15:0] rdata;
      pport_pkg::xfer_state_type xfer;
      logic [pport_pkg::CNT_W-1:0] wait_cnt;
      logic xfer_read;
      logic wr_prev;
      logic rd_prev;
      logic [7:0] pdata_out;
      logic pdata_oe_n;
      logic [10:0] addr_out;
      logic [10:0] addr_oe_n;
      logic cs_out;
      logic cs_oe_n;
      logic strb_rd;
      logic strb_wr;
      logic strb_oe_n;
      logic cal_out;
      logic ttl;
      logic irq;
   } state_type;

   state_type state_reg;
   state_type state_next;
   logic [SYNC_W-1:0] sync_bus;
   logic h_cs;
   logic h_rd;
   logic h_wr;
   logic [1:0] h_addr;
   logic [7:0] h_data;
   logic port_en;
   logic is_master;
   logic slave_act;
   logic host_wr_edge;
   logic host_rd_edge;
   logic [1:0] byte_idx;
   logic xfer_start;

   // ***************************************************
   // Pin input synchronisation
   // ***************************************************
   sync_two_flop #(.WIDTH(SYNC_W)) u_sync (
      .mclk(mclk),
      .rstn(rstn),
      .async_in({host_cs_in, host_rd_in, host_wr_in, host_addr_in, pdata_in}),
      .sync_out(sync_bus)
   );
   assign {h_cs, h_rd, h_wr, h_addr, h_data} = sync_bus;

   function automatic logic [15:0] status_word(state_type st);
      status_word = '0;
      status_word[pport_pkg::ST_IBF] = &st.in_full;
      status_word[pport_pkg::ST_INPUT_OVERFLOW_FLAG] = st.input_overflow_flag;
      status_word[pport_pkg::ST_IBX +: 4] = st.in_full;
      status_word[pport_pkg::ST_OBE] = &st.out_empty;
      status_word[pport_pkg::ST_OUTPUT_UNDERFLOW_FLAG] = st.output_underflow_flag;
      status_word[pport_pkg::ST_OBX +: 4] = st.out_empty;
   endfunction

   // Unmapped offsets and unimplemented bits answer zero.
   function automatic logic [15:0] readback(logic [3:0] a, state_type st);
      case (a)
         pport_pkg::OFS_CONTROL: readback = st.control;
         pport_pkg::OFS_MODE: readback = st.mode;
         pport_pkg::OFS_ADDR: readback = st.taddr;
         pport_pkg::OFS_PIN_EN: readback = st.pin_en;
         pport_pkg::OFS_STATUS: readback = status_word(st);
         pport_pkg::OFS_PAD: readback = st.pad;
         pport_pkg::OFS_OUT1: readback = {st.out_bytes[1], st.out_bytes[0]};
         pport_pkg::OFS_OUT2: readback = {st.out_bytes[3], st.out_bytes[2]};
         pport_pkg::OFS_IN1: readback = {st.in_bytes[1], st.in_bytes[0]};
         pport_pkg::OFS_IN2: readback = {st.in_bytes[3], st.in_bytes[2]};
         pport_pkg::OFS_IRQ_STAT: readback = 16'(st.irq_stat);
         pport_pkg::OFS_IRQ_MASK: readback = 16'(st.irq_mask);
         default: readback = '0;
      endcase
   endfunction

   assign port_en = state_reg.control[pport_pkg::CTL_PORT_EN];
   assign is_master = state_reg.mode[pport_pkg::MODE_SEL_LO + 1];
   assign slave_act = port_en && !is_master;
   assign host_wr_edge = slave_act && h_cs && h_wr && !state_reg.wr_prev;
   assign host_rd_edge = slave_act && h_cs && h_rd && !state_reg.rd_prev;
   // Legacy slave mode has a single byte; addressable mode decodes.
   assign byte_idx = (state_reg.mode[pport_pkg::MODE_SEL_LO +: 2] ==
                      pport_pkg::MODE_ADDR_SLAVE) ? h_addr : 2'b00;
   assign xfer_start = port_en && is_master &&
                       state_reg.xfer == pport_pkg::XFER_IDLE &&
                       ((reg_wr && reg_addr == pport_pkg::OFS_OUT1) ||
                        (reg_rd && reg_addr == pport_pkg::OFS_IN1));

   // ***************************************************
   // Next-state logic
   // ***************************************************
   always_comb begin
      logic [3:0] mid;
      logic [pport_pkg::IRQ_W-1:0] ev;
      logic active;
      logic [15:0] w;
      mid = state_reg.mode[pport_pkg::MIDDLE_LO +: 4];
      active = 1'b0;
      ev = '0;
      w = reg_wdata;
      state_next = state_reg;
      state_next.wr_prev = h_cs && h_wr;
      state_next.rd_prev = h_cs && h_rd;
      state_next.rdata = reg_rd ? readback(reg_addr, state_reg) : '0;
      if (reg_wr) begin
         case (reg_addr)
            pport_pkg::OFS_CONTROL: state_next.control = w & pport_pkg::CTL_MASK;
            pport_pkg::OFS_MODE: state_next.mode =
               (w & pport_pkg::MODE_MASK) |
               (state_reg.mode & ~pport_pkg::MODE_MASK);
            pport_pkg::OFS_ADDR: state_next.taddr = w & pport_pkg::ADDR_MASK;
            pport_pkg::OFS_PIN_EN: state_next.pin_en = w & pport_pkg::PIN_EN_MASK;
            pport_pkg::OFS_PAD: state_next.pad = w & pport_pkg::PAD_MASK;
            pport_pkg::OFS_STATUS: begin
               state_next.input_overflow_flag = w[pport_pkg::ST_INPUT_OVERFLOW_FLAG];
               state_next.output_underflow_flag = w[pport_pkg::ST_OUTPUT_UNDERFLOW_FLAG];
            end
            pport_pkg::OFS_OUT1: begin
               state_next.out_bytes[1:0] = w;
               state_next.out_empty[1:0] = 2'b00;
            end
            pport_pkg::OFS_OUT2: begin
               state_next.out_bytes[3:2] = w;
               state_next.out_empty[3:2] = 2'b00;
            end
            pport_pkg::OFS_IRQ_STAT: state_next.irq_stat =
               state_reg.irq_stat & ~w[pport_pkg::IRQ_W-1:0];
            pport_pkg::OFS_IRQ_MASK: state_next.irq_mask = w[pport_pkg::IRQ_W-1:0];
            default: ;
         endcase
      end
      if (reg_rd && reg_addr == pport_pkg::OFS_IN1) begin
         state_next.in_full[1:0] = 2'b00;
      end
      if (reg_rd && reg_addr == pport_pkg::OFS_IN2) begin
         state_next.in_full[3:2] = 2'b00;
      end
      // Hardware sets come after software clears so that the set wins.
      if (host_wr_edge) begin
         if (state_reg.in_full[byte_idx]) begin
            state_next.input_overflow_flag = 1'b1;
            ev[pport_pkg::IRQ_OVF] = 1'b1;
         end else begin
            state_next.in_bytes[byte_idx] = h_data;
            state_next.in_full[byte_idx] = 1'b1;
            ev[pport_pkg::IRQ_HOST_WR] = 1'b1;
         end
      end
      if (host_rd_edge) begin
         if (state_reg.out_empty[byte_idx]) begin
            state_next.output_underflow_flag = 1'b1;
            ev[pport_pkg::IRQ_UNF] = 1'b1;
         end else begin
            state_next.pdata_out = state_reg.out_bytes[byte_idx];
            state_next.out_empty[byte_idx] = 1'b1;
         end
      end
      // Master transfer: strobe plus optional setup/middle/hold waits,
      // one instruction cycle per mclk cycle.
      case (state_reg.xfer)
         pport_pkg::XFER_IDLE: begin
            if (xfer_start) begin
               state_next.xfer = pport_pkg::XFER_ACTIVE;
               state_next.xfer_read = reg_rd;
               state_next.pdata_out = state_next.out_bytes[0];
               if (mid == 4'h0) begin
                  state_next.wait_cnt = pport_pkg::STROBE_CYCLES;
               end else begin
                  state_next.wait_cnt = pport_pkg::STROBE_CYCLES +
                     pport_pkg::CNT_W'(mid) + pport_pkg::PHASE_BASE +
                     pport_pkg::CNT_W'(state_reg.mode[pport_pkg::SETUP_LO +: 2]) +
                     pport_pkg::PHASE_BASE +
                     pport_pkg::CNT_W'(state_reg.mode[pport_pkg::HOLD_LO +: 2]);
               end
            end
         end
         pport_pkg::XFER_ACTIVE: begin
            if (state_reg.wait_cnt == pport_pkg::STROBE_CYCLES) begin
               state_next.xfer = pport_pkg::XFER_IDLE;
               ev[pport_pkg::IRQ_DONE] = 1'b1;
               if (state_reg.xfer_read) begin
                  state_next.in_bytes[0] = h_data;
                  state_next.in_full[0] = 1'b1;
               end else begin
                  state_next.out_empty[0] = 1'b1;
               end
            end else begin
               state_next.wait_cnt = state_reg.wait_cnt - pport_pkg::STROBE_CYCLES;
            end
         end
         default: state_next.xfer = pport_pkg::XFER_IDLE;
      endcase
      active = state_next.xfer == pport_pkg::XFER_ACTIVE;
      state_next.mode[pport_pkg::MODE_BUSY] = active;
      state_next.irq_stat = state_next.irq_stat | ev;
      state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
      // ***************************************************
      // Pin drive
      // ***************************************************
      state_next.pdata_oe_n = !((active && !state_next.xfer_read) ||
                                (slave_act && h_cs && h_rd));
      state_next.addr_out = state_next.taddr[10:0] &
                            state_next.pin_en[10:0];
      state_next.addr_oe_n[10:2] = ~state_next.pin_en[10:2];
      // Low pins serve as host address inputs in slave modes.
      state_next.addr_oe_n[1:0] = ~(state_next.pin_en[1:0] &
         {2{state_next.mode[pport_pkg::MODE_SEL_LO + 1]}});
      state_next.cs_oe_n = !state_next.pin_en[pport_pkg::PIN_CS];
      state_next.cs_out = active &&
                          state_next.taddr[pport_pkg::ADDR_CS];
      state_next.strb_oe_n = !(port_en && is_master);
      if (state_reg.mode[pport_pkg::MODE_SEL_LO +: 2] ==
          pport_pkg::MODE_MASTER1) begin
         state_next.strb_rd = active && state_next.xfer_read;
         state_next.strb_wr = active;
      end else begin
         state_next.strb_rd = active && state_next.xfer_read;
         state_next.strb_wr = active && !state_next.xfer_read;
      end
      state_next.cal_out = state_next.control[pport_pkg::CTL_CAL_OE] &&
         (state_next.pad[pport_pkg::PAD_SEC] ?
          cal_seconds_clk : cal_alarm_pulse);
      state_next.ttl = state_next.pad[pport_pkg::PAD_TTL];
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
         state_reg.out_empty <= 4'hF;
         state_reg.pdata_oe_n <= 1'b1;
         state_reg.addr_oe_n <= 11'h7FF;
         state_reg.cs_oe_n <= 1'b1;
         state_reg.strb_oe_n <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rdata = state_reg.rdata;
   assign pdata_out = state_reg.pdata_out;
   assign pdata_oe_n = state_reg.pdata_oe_n;
   assign addr_out = state_reg.addr_out;
   assign addr_oe_n = state_reg.addr_oe_n;
   assign cs_out = state_reg.cs_out;
   assign cs_oe_n = state_reg.cs_oe_n;
   assign strobe_rd_out = state_reg.strb_rd;
   assign strobe_wr_out = state_reg.strb_wr;
   assign strobe_oe_n = state_reg.strb_oe_n;
   assign cal_pin_out = state_reg.cal_out;
   assign ttl_select = state_reg.ttl;
   assign irq = state_reg.irq;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   sequence s_one_busy;
      state_reg.mode[pport_pkg::MODE_BUSY] ##1
      !state_reg.mode[pport_pkg::MODE_BUSY];
   endsequence
   property p_busy_start;
      xfer_start |=> state_reg.mode[pport_pkg::MODE_BUSY];
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy not raised at transfer start");
   property p_no_middle;
      xfer_start && state_reg.mode[pport_pkg::MIDDLE_LO +: 4] == 4'h0
         |=> s_one_busy;
   endproperty
   a_no_middle: assert property (p_no_middle)
      else $error("zero middle wait did not give one cycle");
   property p_cs_owner;
      reg_wr && reg_addr == pport_pkg::OFS_PIN_EN
         |=> cs_oe_n == !$past(reg_wdata[pport_pkg::PIN_CS]);
   endproperty
   a_cs_owner: assert property (p_cs_owner)
      else $error("chip-select ownership wrong");
   property p_addr_owner;
      reg_wr && reg_addr == pport_pkg::OFS_PIN_EN
         |=> addr_oe_n[10:2] == ~$past(reg_wdata[10:2]);
   endproperty
   a_addr_owner: assert property (p_addr_owner)
      else $error("upper address ownership wrong");
   property p_addr_present;
      state_reg.mode[pport_pkg::MODE_BUSY] |->
         addr_out == (state_reg.taddr[10:0] & state_reg.pin_en[10:0]);
   endproperty
   a_addr_present: assert property (p_addr_present)
      else $error("address lines do not show the address register");
   property p_cal_gate;
      !state_reg.control[pport_pkg::CTL_CAL_OE] |-> !cal_pin_out;
   endproperty
   a_cal_gate: assert property (p_cal_gate)
      else $error("calendar pin driven while disabled");
   property p_pad_zero;
      reg_rd && reg_addr == pport_pkg::OFS_PAD |=> reg_rdata[15:2] == '0;
   endproperty
   a_pad_zero: assert property (p_pad_zero)
      else $error("unimplemented pad bits read nonzero");
   property p_overflow;
      host_wr_edge && state_reg.in_full[byte_idx]
         |=> state_reg.input_overflow_flag;
   endproperty
   a_overflow: assert property (p_overflow)
      else $error("overflow flag not set");
   property p_underflow;
      host_rd_edge && state_reg.out_empty[byte_idx] |=> state_reg.output_underflow_flag;
   endproperty
   a_underflow: assert property (p_underflow)
      else $error("underflow flag not set");
   property p_full_clear;
      reg_rd && reg_addr == pport_pkg::OFS_IN1 && !host_wr_edge
         |=> state_reg.in_full[1:0] == 2'b00;
   endproperty
   a_full_clear: assert property (p_full_clear)
      else $error("input full flags not cleared by read");
   property p_disabled;
      !port_en && !state_reg.mode[pport_pkg::MODE_BUSY]
         |=> !state_reg.mode[pport_pkg::MODE_BUSY] && strobe_oe_n;
   endproperty
   a_disabled: assert property (p_disabled)
      else $error("disabled port made an access");
endmodule // parallel_port_config_status

// ===== src/sync_two_flop.sv
// Two-flop synchroniser for a vector of asynchronous pin inputs.
module sync_two_flop #(
   parameter int WIDTH = 1
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   if (WIDTH < 1) begin : g_width_check
      $error("sync_two_flop: WIDTH must be positive");
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // sync_two_flop

// ===== tb/host_model.sv
// External host processor model driving the slave-side pins.
module host_model (
   input wire logic mclk,
   input wire logic [7:0] pdata_out,
   output logic host_cs_in,
   output logic host_rd_in,
   output logic host_wr_in,
   output logic [1:0] host_addr_in,
   output logic [7:0] pdata_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      host_cs_in = 1'b0;
      host_rd_in = 1'b0;
      host_wr_in = 1'b0;
      host_addr_in = 2'b00;
      pdata_in = 8'h5A;
   end
   // Strobes stay four edges per level, beyond the two-flop sync need.
   task automatic hwrite(input logic [1:0] a, input logic [7:0] d);
      @(posedge mclk);
      host_addr_in <= a;
      pdata_in <= d;
      host_cs_in <= 1'b1;
      host_wr_in <= 1'b1;
      repeat (4) @(posedge mclk);
      host_cs_in <= 1'b0;
      host_wr_in <= 1'b0;
      // A released bus shows no stale value.
      pdata_in <= ~d;
      repeat (4) @(posedge mclk);
   endtask
   task automatic hread(input logic [1:0] a);
      @(posedge mclk);
      host_addr_in <= a;
      host_cs_in <= 1'b1;
      host_rd_in <= 1'b1;
      repeat (4) @(posedge mclk);
      host_cs_in <= 1'b0;
      host_rd_in <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask
endmodule // host_model

// ===== tb/parallel_port_config_status_tb.sv
// Self-checking bench for the parallel port configuration block.
module parallel_port_config_status_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, rstn, reg_wr, reg_rd, host_cs_in, host_rd_in, host_wr_in;
   logic cal_seconds_clk, cal_alarm_pulse, pdata_oe_n, cs_out, cs_oe_n;
   logic strobe_rd_out, strobe_wr_out, strobe_oe_n, cal_pin_out;
   logic ttl_select, irq;
   logic [3:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata, rv;
   logic [1:0] host_addr_in;
   logic [7:0] pdata_in, pdata_out;
   logic [10:0] addr_out, addr_oe_n;
   int num_errors = 0;
   int num_checks = 0;
   parallel_port_config_status dut (.mclk(mclk), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_cs_in(host_cs_in),
      .host_rd_in(host_rd_in), .host_wr_in(host_wr_in),
      .host_addr_in(host_addr_in), .pdata_in(pdata_in),
      .pdata_out(pdata_out), .pdata_oe_n(pdata_oe_n), .addr_out(addr_out),
      .addr_oe_n(addr_oe_n), .cs_out(cs_out), .cs_oe_n(cs_oe_n),
      .strobe_rd_out(strobe_rd_out), .strobe_wr_out(strobe_wr_out),
      .strobe_oe_n(strobe_oe_n), .cal_seconds_clk(cal_seconds_clk),
      .cal_alarm_pulse(cal_alarm_pulse), .cal_pin_out(cal_pin_out),
      .ttl_select(ttl_select), .irq(irq));
   host_model host (.mclk(mclk), .pdata_out(pdata_out),
      .host_cs_in(host_cs_in), .host_rd_in(host_rd_in),
      .host_wr_in(host_wr_in), .host_addr_in(host_addr_in),
      .pdata_in(pdata_in));
   // ***************************************************
   // Bus tasks and comparison
   // ***************************************************
   task automatic chk(input string n, input logic [15:0] g, e);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ***************************************************
   // Scenarios
   // ***************************************************
   task automatic t_config();
      rd(pport_pkg::OFS_STATUS);
      chk("status", rv, 16'h008F);
      rd(4'hF);
      chk("unmapped", rv, 16'h0000);
      wr(pport_pkg::OFS_PIN_EN, 16'hFFFF);
      rd(pport_pkg::OFS_PIN_EN);
      chk("pin_en", rv, 16'h47FF);
      chk("cs_oe_n", {15'h0000, cs_oe_n}, 16'h0000);
      chk("addr_oe_n", {7'h00, addr_oe_n[10:2]}, 16'h0000);
      chk("low_slave", {14'h0000, addr_oe_n[1:0]}, 16'h0003);
      wr(pport_pkg::OFS_PAD, 16'hFFFF);
      wr(pport_pkg::OFS_CONTROL, 16'h0400);
      repeat (2) @(posedge mclk);
      #1 chk("ttl", {15'h0000, ttl_select}, 16'h0001);
      chk("cal_sec", {15'h0000, cal_pin_out}, 16'h0001);
      wr(pport_pkg::OFS_PAD, 16'h0001);
      repeat (2) @(posedge mclk);
      #1 chk("cal_alarm", {15'h0000, cal_pin_out}, 16'h0000);
      wr(pport_pkg::OFS_CONTROL, 16'h0000);
      cal_alarm_pulse <= 1'b1;
      repeat (2) @(posedge mclk);
      #1 chk("cal_off", {15'h0000, cal_pin_out}, 16'h0000);
   endtask
   task automatic t_slave();
      wr(pport_pkg::OFS_CONTROL, 16'h8000);
      wr(pport_pkg::OFS_MODE, 16'h0100);
      wr(pport_pkg::OFS_IRQ_MASK, 16'h0001);
      host.hwrite(2'b10, 8'hA5);
      rd(pport_pkg::OFS_STATUS);
      chk("full2", rv, 16'h048F);
      chk("irq_masked", {15'h0000, irq}, 16'h0000);
      host.hwrite(2'b10, 8'h3C);
      rd(pport_pkg::OFS_STATUS);
      chk("overflow", rv, 16'h448F);
      chk("irq", {15'h0000, irq}, 16'h0001);
      rd(pport_pkg::OFS_IN2);
      chk("in2", rv & 16'h00FF, 16'h00A5);
      rd(pport_pkg::OFS_STATUS);
      chk("read_clr", rv, 16'h408F);
      wr(pport_pkg::OFS_IRQ_STAT, 16'h0001);
      wr(pport_pkg::OFS_STATUS, 16'h0000);
      rd(pport_pkg::OFS_STATUS);
      chk("sw_clr", rv, 16'h008F);
      chk("irq_clr", {15'h0000, irq}, 16'h0000);
      host.hread(2'b01);
      rd(pport_pkg::OFS_STATUS);
      chk("underflow", rv, 16'h00CF);
      wr(pport_pkg::OFS_OUT2, 16'hBE00);
      // The host read is loaded three edges after its strobe rises.
      fork
         host.hread(2'b11);
         begin
            repeat (4) @(posedge mclk);
            #1 chk("host_rd", {8'h00, pdata_out}, 16'h00BE);
            chk("rd_drive", {15'h0000, pdata_oe_n}, 16'h0000);
         end
      join
   endtask
   task automatic t_master1();
      wr(pport_pkg::OFS_CONTROL, 16'h8000);
      wr(pport_pkg::OFS_MODE, 16'h0304);
      rd(pport_pkg::OFS_IN1);
      chk("enable_strobe", {15'h0000, strobe_wr_out}, 16'h0001);
      chk("rw_level", {15'h0000, strobe_rd_out}, 16'h0001);
      chk("strobe_oe_n", {15'h0000, strobe_oe_n}, 16'h0000);
      chk("low_oe_n", {14'h0000, addr_oe_n[1:0]}, 16'h0000);
      rd(pport_pkg::OFS_MODE);
      chk("busy", rv, 16'h8304);
      // One middle wait plus one setup and one hold cycle: four busy cycles.
      @(posedge mclk);
      #1 chk("long", {15'h0000, strobe_wr_out}, 16'h0001);
      @(posedge mclk);
      #1 chk("done", {15'h0000, strobe_wr_out}, 16'h0000);
      rd(pport_pkg::OFS_IN1);
      chk("in1", rv, {8'h00, ~8'h3C});
      repeat (5) @(posedge mclk);
   endtask
   task automatic t_master();
      wr(pport_pkg::OFS_ADDR, 16'h4123);
      wr(pport_pkg::OFS_MODE, 16'h02C3);
      wr(pport_pkg::OFS_OUT1, 16'h0077);
      chk("wr_strobe", {15'h0000, strobe_wr_out}, 16'h0001);
      chk("cs_level", {15'h0000, cs_out}, 16'h0001);
      chk("addr", {5'h00, addr_out}, 16'h0123);
      @(posedge mclk);
      #1 chk("short", {15'h0000, strobe_wr_out}, 16'h0000);
      wr(pport_pkg::OFS_CONTROL, 16'h0000);
      wr(pport_pkg::OFS_OUT1, 16'h0011);
      chk("disabled", {15'h0000, strobe_wr_out}, 16'h0000);
      chk("strobe_off", {15'h0000, strobe_oe_n}, 16'h0001);
   endtask
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial begin
      #100us;
      num_errors++;
      summarize();
   end
   initial begin
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 16'h0000;
      cal_seconds_clk = 1'b1;
      cal_alarm_pulse = 1'b0;
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_config();
      t_slave();
      t_master1();
      t_master();
      summarize();
   end
endmodule // parallel_port_config_status_tb
